// ### rtl/flag_guard.sv
// Flash lock access guard: grants or refuses flash requests from debug and firmware.
// Assumes one request per cycle from a single arbitrated port, and a flash controller that acts on grant.
`timescale 1ns/100ps
// Contract
// (RQ1) Debug requests to any unlocked page are granted for read, write and erase.
// (RQ2) Debug requests and unlocked-page firmware requests to a locked page are refused.
// (RQ3) Debug may reach the lock byte page only while that page is unlocked.
// (RQ4) A read of the lock byte itself is always granted.
// (RQ5) A write that clears lock byte bits from 1 to 0 is refused for every requester; the code grants it while the lock byte is still all ones.
// (RQ6) Only a debug whole-device erase unlocks pages, and it resets the lock byte to all ones; the code also loads all ones into the lock byte on rst.
// (RQ7) Firmware may never set lock byte bits from 0 to 1.
// (RQ8) The reserved area is refused to every requester.
// (RQ9) A refused firmware request raises a one-cycle flash-error reset.
// (RQ10) Firmware may reach any unlocked page other than the lock byte page.
// (RQ11) Firmware on a locked page may reach locked pages other than the lock byte page.
// (RQ12) Unlocked-page firmware never erases the lock byte page and reads or writes it only while unlocked.
// (RQ13) Locked-page firmware may read and write the lock byte page but never erase it.
// (RQ14) Page lock status comes from the lock byte and the fetch address classifies firmware.
module flag_guard (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire flag_pkg::flag_req_s req,
  input  wire logic [14:0]         fetch_addr,
  output flag_pkg::flag_rsp_s      rsp_r,
  output logic                     flash_err_rst_r,
  output logic [7:0]               lock_byte_r
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [63:0] page_locked;
  logic        fetch_locked;
  logic [5:0]  page;
  logic        tgt_locked;
  logic        is_rsvd;
  logic        is_lock_pg;
  logic        is_lock_adr;
  logic        lock_set_bit;
  logic        lock_clr_bit;
  logic        is_read;
  logic        is_write;
  logic        is_erase;
  logic        is_mass;
  logic        dbg_req;
  logic        fw_req;
  logic        any_locked;
  logic        allow;
  logic        grant_nxt;

  flag_page_map u_map (
    .lock_byte    (lock_byte_r),
    .fetch_addr   (fetch_addr),
    .page_locked  (page_locked),
    .fetch_locked (fetch_locked)
  );

  assign page         = req.addr[flag_pkg::ADDR_W-1:flag_pkg::PAGE_OFS_W];
  assign tgt_locked   = page_locked[page];
  assign is_rsvd      = page >= flag_pkg::RSVD_PAGE_LO;
  assign is_lock_pg   = page == flag_pkg::LOCK_PAGE;
  assign is_lock_adr  = req.addr == flag_pkg::LOCK_ADDR;
  assign is_read      = req.op == flag_pkg::FLAG_OP_READ;
  assign is_write     = req.op == flag_pkg::FLAG_OP_WRITE;
  assign is_erase     = req.op == flag_pkg::FLAG_OP_ERASE;
  assign is_mass      = req.op == flag_pkg::FLAG_OP_MASS_ERASE;
  assign dbg_req      = req.valid && req.from_dbg;
  assign fw_req       = req.valid && !req.from_dbg;
  assign any_locked   = lock_byte_r != flag_pkg::LOCK_BYTE_RST;
  // Programming an erased lock byte is the first lock, not an additional one
  assign lock_clr_bit = any_locked && |(lock_byte_r & ~req.wdata); // RQ5
  assign lock_set_bit = |(~lock_byte_r & req.wdata); // RQ7

  // ---------------------------------------------------------------
  // Permission
  // ---------------------------------------------------------------
  always_comb begin
    allow = 1'b0;
    if (req.op == flag_pkg::FLAG_OP_MASS_ERASE) begin
      allow = req.from_dbg; // RQ6
    end else if (is_rsvd) begin
      allow = 1'b0; // RQ8
    end else if (is_lock_adr && req.op == flag_pkg::FLAG_OP_READ) begin
      allow = 1'b1; // RQ4
    end else if (req.from_dbg) begin
      allow = !tgt_locked; // RQ1 RQ2 RQ3
    end else if (is_lock_pg) begin
      if (req.op == flag_pkg::FLAG_OP_ERASE) begin
        allow = 1'b0; // RQ12 RQ13
      end else begin
        allow = fetch_locked || !tgt_locked; // RQ12 RQ13
      end
    end else begin
      allow = fetch_locked || !tgt_locked; // RQ2 RQ10 RQ11
    end
    if (is_lock_adr && req.op == flag_pkg::FLAG_OP_WRITE) begin
      if (lock_clr_bit || (!req.from_dbg && lock_set_bit)) begin
        allow = 1'b0; // RQ5 RQ7
      end
    end
  end

  assign grant_nxt = req.valid && allow;

  // ---------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.done   <= req.valid;
      rsp_r.grant  <= grant_nxt;
      rsp_r.refuse <= req.valid && !allow;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_err_rst_r <= flag_pkg::ERR_RST;
    end else begin
      flash_err_rst_r <= req.valid && !req.from_dbg && !allow; // RQ9
    end
  end

  // ---------------------------------------------------------------
  // Lock byte shadow
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_byte_r <= flag_pkg::LOCK_BYTE_RST;
    end else if (req.valid && req.from_dbg && req.op == flag_pkg::FLAG_OP_MASS_ERASE) begin
      lock_byte_r <= flag_pkg::LOCK_BYTE_RST; // RQ6
    end else if (grant_nxt && is_lock_pg && req.op == flag_pkg::FLAG_OP_ERASE) begin
      lock_byte_r <= flag_pkg::LOCK_BYTE_RST;
    end else if (grant_nxt && is_lock_adr && req.op == flag_pkg::FLAG_OP_WRITE) begin
      lock_byte_r <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  rsvd_refused_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ8
    req.valid && req.op != flag_pkg::FLAG_OP_MASS_ERASE && is_rsvd |=> rsp_r.refuse && !rsp_r.grant)
    else $error("reserved area access granted");
  fw_err_reset_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
    req.valid && !req.from_dbg && !allow |=> flash_err_rst_r ##1 (!flash_err_rst_r || $past(fw_req && !allow)))
    else $error("firmware refusal without error reset");
  dbg_no_err_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    req.valid && req.from_dbg |=> !flash_err_rst_r)
    else $error("debug request raised error reset");
  lock_read_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
    req.valid && is_lock_adr && req.op == flag_pkg::FLAG_OP_READ |=> rsp_r.grant)
    else $error("lock byte read refused");
  no_lock_more_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
    req.valid && is_lock_adr && req.op == flag_pkg::FLAG_OP_WRITE && lock_clr_bit |=> !rsp_r.grant)
    else $error("lock byte bit cleared");
  fw_no_unlock_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
    !req.from_dbg |=> (~$past(lock_byte_r) & lock_byte_r) == 8'h00)
    else $error("firmware raised lock bits");
  mass_erase_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    req.valid && req.from_dbg && req.op == flag_pkg::FLAG_OP_MASS_ERASE
    |=> lock_byte_r == flag_pkg::LOCK_BYTE_RST && rsp_r.grant)
    else $error("mass erase did not unlock");
  dbg_locked_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    req.valid && req.from_dbg && tgt_locked && !is_lock_adr && req.op != flag_pkg::FLAG_OP_MASS_ERASE
    |=> rsp_r.refuse)
    else $error("debug reached locked page");
  lock_pg_erase_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ13
    req.valid && !req.from_dbg && is_lock_pg && req.op == flag_pkg::FLAG_OP_ERASE |=> flash_err_rst_r)
    else $error("firmware erased lock page");

  // ---------------------------------------------------------------
  // Checks on outcomes and lock byte history
  // ---------------------------------------------------------------
  one_outcome_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    req.valid |=> rsp_r.done && (rsp_r.grant != rsp_r.refuse))
    else $error("request without single outcome");
  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
    !req.valid |=> !rsp_r.done && !rsp_r.grant && !rsp_r.refuse && !flash_err_rst_r)
    else $error("response without request");
  err_is_refuse_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
    flash_err_rst_r |-> rsp_r.refuse)
    else $error("error reset without refusal");
  rsvd_err_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ9
    fw_req && is_rsvd && !is_mass |=> flash_err_rst_r)
    else $error("reserved access without error reset");
  dbg_unlocked_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
    dbg_req && !is_mass && !is_rsvd && !tgt_locked |=> rsp_r.grant)
    else $error("debug refused unlocked page");
  dbg_lock_pg_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ3
    dbg_req && !is_mass && is_lock_pg && tgt_locked && !(is_lock_adr && is_read) |=> rsp_r.refuse)
    else $error("debug reached locked lock page");
  dbg_lock_pg_ok_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ3
    dbg_req && !is_mass && is_lock_pg && !tgt_locked |=> rsp_r.grant)
    else $error("debug refused unlocked lock page");
  fw_unlocked_ok_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ10
    fw_req && !is_mass && !is_rsvd && !is_lock_pg && !tgt_locked |=> rsp_r.grant)
    else $error("firmware refused unlocked page");
  fw_locked_ok_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ11
    fw_req && fetch_locked && !is_mass && !is_rsvd && !is_lock_pg |=> rsp_r.grant)
    else $error("locked firmware refused page");
  fw_locked_deny_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    fw_req && !fetch_locked && tgt_locked && !is_mass && !(is_lock_adr && is_read)
    |=> rsp_r.refuse && flash_err_rst_r)
    else $error("unlocked firmware reached locked page");
  fw_lock_pg_rw_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ13
    fw_req && fetch_locked && is_lock_pg && !is_lock_adr && (is_read || is_write) |=> rsp_r.grant)
    else $error("locked firmware refused lock page");
  fw_unl_lock_pg_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ12
    fw_req && !fetch_locked && is_lock_pg && !tgt_locked && (is_read || is_write) |=> rsp_r.grant)
    else $error("firmware refused unlocked lock page");
  lock_pg_refuse_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ12
    fw_req && is_lock_pg && is_erase |=> rsp_r.refuse)
    else $error("firmware lock page erase granted");
  fw_mass_deny_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    fw_req && is_mass |=> rsp_r.refuse && flash_err_rst_r)
    else $error("firmware mass erase granted");
  lock_stable_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ14
    !req.valid |=> $stable(lock_byte_r))
    else $error("lock byte moved without request");
  lock_written_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ14
    req.valid && is_lock_adr && is_write |=> !rsp_r.grant || lock_byte_r == $past(req.wdata))
    else $error("granted lock byte write lost");
  locked_no_more_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
    any_locked |=> ($past(lock_byte_r) & ~lock_byte_r) == 8'h00)
    else $error("extra pages locked");
  only_mass_unl_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    any_locked && !(dbg_req && is_mass) |=> (~$past(lock_byte_r) & lock_byte_r) == 8'h00)
    else $error("pages unlocked without mass erase");
endmodule

// ### rtl/flag_pkg.sv
// Package for the flash lock access guard: page geometry, request types and carriers.
// Assumes a 32 kB flash split into 512-byte pages with the lock byte in the top usable page.
package flag_pkg;
  localparam int unsigned ADDR_W        = 15;
  localparam int unsigned PAGE_W        = 6;
  localparam int unsigned PAGE_OFS_W    = 9;
  localparam int unsigned NUM_PAGES     = 64;
  localparam logic [5:0]  LOCK_PAGE     = 6'h3e;
  localparam logic [14:0] LOCK_ADDR     = 15'h7dff;
  localparam logic [5:0]  RSVD_PAGE_LO  = 6'h3f;
  localparam logic [7:0]  LOCK_BYTE_RST = 8'hff;
  localparam logic        GRANT_RST     = 1'b0;
  localparam logic        ERR_RST       = 1'b0;

  typedef enum logic [1:0] {
    FLAG_OP_READ,
    FLAG_OP_WRITE,
    FLAG_OP_ERASE,
    FLAG_OP_MASS_ERASE
  } flag_op_e;

  typedef struct packed {
    logic          valid;
    logic          from_dbg;
    flag_op_e      op;
    logic [14:0]   addr;
    logic [7:0]    wdata;
  } flag_req_s;

  typedef struct packed {
    logic          done;
    logic          grant;
    logic          refuse;
  } flag_rsp_s;
endpackage

// ### rtl/flag_page_map.sv
// Page lock map: turns the lock byte into a per-page locked vector.
// Assumes the lock byte holds the count of locked pages as its ones complement, counted down from the top.
`timescale 1ns/100ps
module flag_page_map (
  input  wire logic [7:0]  lock_byte,
  input  wire logic [14:0] fetch_addr,
  output logic [63:0]      page_locked,
  output logic             fetch_locked
);
  logic [7:0] locked_cnt;
  assign locked_cnt = ~lock_byte;

  // ---------------------------------------------------------------
  // Lock vector, one bit per page
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < flag_pkg::NUM_PAGES; g++) begin : g_page
      localparam logic [7:0] FROM_TOP = 8'(flag_pkg::LOCK_PAGE) - 8'(g);
      assign page_locked[g] = (g <= int'(flag_pkg::LOCK_PAGE)) && (locked_cnt != 8'h00)
                              && (FROM_TOP < locked_cnt); // RQ14
    end
  endgenerate

  assign fetch_locked = page_locked[fetch_addr[14:9]]; // RQ14
endmodule

// ### tb/flag_requester.sv
// Requester model: the core and the debug port issuing flash requests.
// Assumes each call starts one small delay after a rising edge; the next edge takes the request.
`timescale 1ns/100ps
module flag_requester (
  input  wire logic           clk_sys,
  output flag_pkg::flag_req_s req,
  output logic [14:0]         fetch_addr
);
  initial begin
    req = '0;
    fetch_addr = 15'h0000;
  end
  // Held through the taking edge, then address and data turn to junk
  task automatic issue(input logic dbg, input logic [1:0] op, input logic [14:0] a, input logic [7:0] d,
                       input logic [14:0] f);
    req = '{1'b1, dbg, flag_pkg::flag_op_e'(op), a, d};
    fetch_addr = f;
    @(posedge clk_sys);
    #1 req.valid = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask
endmodule

// ### tb/tb_top.sv
// Testbench for the flash lock access guard: table of requests, then reset.
// Assumes the answer is registered at the edge that takes the request and is read just after it.
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic        dbg;
    logic [1:0]  op;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [14:0] fetch;
    logic [2:0]  rsp;
    logic        err;
    logic [7:0]  lock;
  } flag_row_s;
  // Fetch in an unlocked page, and a page that a lock byte of 8'hfc locks
  localparam logic [14:0] FU = 15'h0000;
  localparam logic [14:0] LK = 15'h7800;
  localparam logic [14:0] LB = flag_pkg::LOCK_ADDR;
  localparam logic [14:0] LP = {flag_pkg::LOCK_PAGE, 9'h000};
  localparam logic [14:0] RS = {flag_pkg::RSVD_PAGE_LO, 9'h000};
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  flag_pkg::flag_req_s req;
  logic [14:0]         fetch_addr;
  flag_pkg::flag_rsp_s rsp_r;
  logic                flash_err_rst_r;
  logic [7:0]          lock_byte_r;
  int                  fail_count = 0;
  int                  checked = 0;
  int                  cycles = 0;
  flag_row_s           rows [28];
  always #10 clk_sys = ~clk_sys;
  flag_requester i_flag_requester (.clk_sys(clk_sys), .req(req), .fetch_addr(fetch_addr));
  flag_guard i_flag_guard (.clk_sys(clk_sys), .rst(rst), .req(req), .fetch_addr(fetch_addr),
    .rsp_r(rsp_r), .flash_err_rst_r(flash_err_rst_r), .lock_byte_r(lock_byte_r));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{
      '{1'b1, 2'h0, 15'h0000, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b1, 2'h1, 15'h1200, 8'h5a, FU, 3'h6, 1'b0, 8'hff},
      '{1'b1, 2'h2, LK, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b1, 2'h0, LB, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b1, 2'h2, LP, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b1, 2'h0, RS, 8'h00, FU, 3'h5, 1'b0, 8'hff},
      '{1'b0, 2'h0, 15'h0100, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b0, 2'h1, LP, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b0, 2'h2, LP, 8'h00, FU, 3'h5, 1'b1, 8'hff},
      '{1'b0, 2'h0, RS, 8'h00, FU, 3'h5, 1'b1, 8'hff},
      '{1'b0, 2'h3, 15'h0000, 8'h00, FU, 3'h5, 1'b1, 8'hff},
      '{1'b1, 2'h1, LB, 8'hfc, FU, 3'h6, 1'b0, 8'hfc},
      '{1'b1, 2'h0, LK, 8'h00, FU, 3'h5, 1'b0, 8'hfc},
      '{1'b1, 2'h1, LP, 8'h00, FU, 3'h5, 1'b0, 8'hfc},
      '{1'b1, 2'h0, LB, 8'h00, FU, 3'h6, 1'b0, 8'hfc},
      '{1'b0, 2'h1, LB, 8'hf8, LK, 3'h5, 1'b1, 8'hfc},
      '{1'b0, 2'h1, LB, 8'hfe, LK, 3'h5, 1'b1, 8'hfc},
      '{1'b0, 2'h1, LP, 8'h00, LK, 3'h6, 1'b0, 8'hfc},
      '{1'b0, 2'h2, LP, 8'h00, LK, 3'h5, 1'b1, 8'hfc},
      '{1'b0, 2'h0, LK, 8'h00, LK, 3'h6, 1'b0, 8'hfc},
      '{1'b0, 2'h2, 15'h1000, 8'h00, LK, 3'h6, 1'b0, 8'hfc},
      '{1'b0, 2'h0, RS, 8'h00, LK, 3'h5, 1'b1, 8'hfc},
      '{1'b0, 2'h0, LK, 8'h00, FU, 3'h5, 1'b1, 8'hfc},
      '{1'b0, 2'h1, LP, 8'h00, FU, 3'h5, 1'b1, 8'hfc},
      '{1'b0, 2'h0, LB, 8'h00, FU, 3'h6, 1'b0, 8'hfc},
      '{1'b1, 2'h0, 15'h0000, 8'h00, FU, 3'h6, 1'b0, 8'hfc},
      '{1'b1, 2'h3, 15'h0000, 8'h00, FU, 3'h6, 1'b0, 8'hff},
      '{1'b1, 2'h0, LK, 8'h00, FU, 3'h6, 1'b0, 8'hff}};
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    chk({rsp_r, flash_err_rst_r, lock_byte_r}, 16'h00ff);
    foreach (rows[i]) begin
      i_flag_requester.issue(rows[i].dbg, rows[i].op, rows[i].addr, rows[i].wdata, rows[i].fetch);
      chk({rsp_r, flash_err_rst_r}, {rows[i].rsp, rows[i].err});
      @(posedge clk_sys);
      #1 chk(lock_byte_r, rows[i].lock);
    end
    // Reset lands while pages are locked and a firmware refusal is being shown
    i_flag_requester.issue(1'b1, 2'h1, LB, 8'hfc, FU);
    chk(lock_byte_r, 8'hfc);
    @(posedge clk_sys);
    #1 i_flag_requester.issue(1'b0, 2'h1, RS, 8'h00, FU);
    chk(flash_err_rst_r, 1'b1);
    rst = 1'b1;
    #1 chk({rsp_r, flash_err_rst_r, lock_byte_r}, 16'h00ff);
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    i_flag_requester.issue(1'b1, 2'h0, 15'h0000, 8'h00, FU);
    chk({rsp_r, flash_err_rst_r}, 4'hc);
    complete_run();
  end
endmodule
